// ===== atc_consts.svh
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------------
`define ATC_OFS_CTRL 5'h00
`define ATC_OFS_FCOUNT 5'h04
`define ATC_OFS_PERIOD 5'h08
`define ATC_OFS_CMD 5'h0C
`define ATC_OFS_STATUS 5'h10
`define ATC_OFS_BURST 5'h14

// ----------------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------------
`define ATC_B_ACQ_ON 0
`define ATC_B_FRM_ON 1
`define ATC_B_LEGACY 2
`define ATC_B_ACQ_SRC 3
`define ATC_B_ACQ_ACT 4
`define ATC_B_FRM_SRC 5
`define ATC_B_FRM_ACT 6
`define ATC_B_RATE_EN 7

// ----------------------------------------------------------------------
// command and status bit positions
// ----------------------------------------------------------------------
`define ATC_B_CMD_ACQ 0
`define ATC_B_CMD_FRM 1
`define ATC_B_ST_WACQ 0
`define ATC_B_ST_WFRM 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ATC_RST_CTRL 8'h04
`define ATC_RST_FCOUNT 32'h0000_0001
`define ATC_RST_PERIOD 32'h0003_0D40

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ATC_CLK_PERIOD_NS 5
`define ATC_MIN_GAP_NS 100
`define ATC_MIN_GAP_CYC ((`ATC_MIN_GAP_NS + `ATC_CLK_PERIOD_NS - 1) / `ATC_CLK_PERIOD_NS)
`define ATC_TIMER_RESTART 2

`endif

// ===== atc_pkg.sv
package atc_pkg;

	// acquisition status, one-hot
	typedef enum logic [1:0] {
		ATC_ST_WAIT_ACQ = 2'b01,
		ATC_ST_WAIT_FRAME = 2'b10
	} atc_state_t;

endpackage

// ===== atc_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none

module atc_edge_detect (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pin_in,
	output logic rise,
	output logic fall
);

	logic sync_a;
	logic sync_b;
	logic prev;

	// two-stage synchroniser, then one more sample for edge compare
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			prev <= 1'b0;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
			prev <= sync_b;
		end
	end

	// only the second stage and later are compared
	assign rise = sync_b & ~prev;
	assign fall = ~sync_b & prev;

endmodule

`default_nettype wire

// ===== atc_frame_timer.sv
`timescale 1ns/10ps
`default_nettype none

`include "atc_consts.svh"

module atc_frame_timer #(
	parameter int CNT_W = 32,
	parameter int MIN_GAP = 20
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic restart,
	input wire logic rate_en,
	input wire logic [CNT_W-1:0] period,
	output logic ready
);

	localparam logic [CNT_W-1:0] MIN_GAP_V = CNT_W'(MIN_GAP);
	localparam logic [CNT_W-1:0] RESTART_V = CNT_W'(`ATC_TIMER_RESTART);

	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] target;

	// saturating count since the last frame start; starts saturated so
	// the first internal trigger is not delayed after reset
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			count <= '1;
		end else if (restart) begin
			count <= RESTART_V;
		end else if (count != '1) begin
			count <= count + 1'b1;
		end
	end

	// programmed rate never beats the fastest rate the settings allow
	always_comb begin
		target = MIN_GAP_V;
		if (rate_en && period > MIN_GAP_V) begin
			target = period;
		end
	end

	// the count is still stale while the restart pulse stands, so ready
	// is held off then; otherwise one trigger would give two frames
	assign ready = (count >= target) && !restart;

endmodule

`default_nettype wire

// ===== atc_trigger_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

`include "atc_consts.svh"

module atc_trigger_ctrl #(
	parameter int FCNT_W = 16,
	parameter int PER_W = 32,
	parameter int MIN_GAP = `ATC_MIN_GAP_CYC
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic line1_in,
	input wire logic frame_busy,
	output logic frame_start,
	output logic waiting_acq,
	output logic waiting_frame
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// merge write data into an old word under byte enables
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] wdata, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// pick a trigger event from source and activation
	function automatic logic sel_trig(input logic src_sw, input logic act_fall,
		input logic sw, input logic rise, input logic fall);
		logic hit;
		hit = act_fall ? fall : rise;
		if (src_sw) begin
			hit = sw;
		end
		return hit;
	endfunction

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic bus_ack;
	logic wr_en;
	logic [7:0] ctrl;
	logic [FCNT_W-1:0] frame_count;
	logic [PER_W-1:0] frame_period;
	logic sw_acq;
	logic sw_frame;
	logic line_rise;
	logic line_fall;
	logic timer_ready;
	atc_pkg::atc_state_t state;
	atc_pkg::atc_state_t next_state;
	logic [FCNT_W-1:0] burst_cnt;
	logic acq_gate;
	logic acq_hit;
	logic ext_frame_hit;
	logic frame_trig;
	logic acq_start;
	logic accept;
	logic burst_last;
	logic [31:0] next_readdata;

	// ------------------------------------------------------------------
	// avalon slave: one wait state per access
	// ------------------------------------------------------------------

	// ack goes high for one cycle after a request is seen
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= (avs_read | avs_write) & ~bus_ack;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
	assign wr_en = avs_write & bus_ack; // takes effect as wait drops

	// control, frame count and period registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `ATC_RST_CTRL;
			frame_count <= FCNT_W'(`ATC_RST_FCOUNT);
			frame_period <= PER_W'(`ATC_RST_PERIOD);
		end else if (wr_en) begin
			case (avs_address)
				`ATC_OFS_CTRL: begin
					ctrl <= 8'(be_merge(32'(ctrl), avs_writedata,
						avs_byteenable));
				end
				`ATC_OFS_FCOUNT: begin
					frame_count <= FCNT_W'(be_merge(32'(frame_count),
						avs_writedata, avs_byteenable));
				end
				`ATC_OFS_PERIOD: begin
					frame_period <= PER_W'(be_merge(32'(frame_period),
						avs_writedata, avs_byteenable));
				end
				default: begin
				end
			endcase
		end
	end

	// software trigger commands: one-cycle pulses, nothing stored
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sw_acq <= 1'b0;
			sw_frame <= 1'b0;
		end else begin
			sw_acq <= wr_en && avs_address == `ATC_OFS_CMD &&
				avs_byteenable[0] && avs_writedata[`ATC_B_CMD_ACQ];
			sw_frame <= wr_en && avs_address == `ATC_OFS_CMD &&
				avs_byteenable[0] && avs_writedata[`ATC_B_CMD_FRM];
		end
	end

	// read mux; unmapped and write-only words read as zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (avs_address)
			`ATC_OFS_CTRL: next_readdata = 32'(ctrl);
			`ATC_OFS_FCOUNT: next_readdata = 32'(frame_count);
			`ATC_OFS_PERIOD: next_readdata = 32'(frame_period);
			`ATC_OFS_STATUS: begin
				next_readdata[`ATC_B_ST_WACQ] = waiting_acq;
				next_readdata[`ATC_B_ST_WFRM] = waiting_frame;
			end
			`ATC_OFS_BURST: next_readdata = 32'(burst_cnt);
			default: next_readdata = 32'h0000_0000;
		endcase
	end

	// read data captured in the wait cycle, stands as wait drops
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !bus_ack) begin
			avs_readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------------
	// trigger sources
	// ------------------------------------------------------------------

	// input line: synchronised, edges found by sample compare
	atc_edge_detect u_line1 (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in(line1_in),
		.rise(line_rise),
		.fall(line_fall)
	);

	// internal frame rate generator, restarted by each frame start
	atc_frame_timer #(
		.CNT_W(PER_W),
		.MIN_GAP(MIN_GAP)
	) u_timer (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.restart(frame_start),
		.rate_en(ctrl[`ATC_B_RATE_EN]),
		.period(frame_period),
		.ready(timer_ready)
	);

	// legacy mode has no acquisition-level trigger at all
	assign acq_gate = ctrl[`ATC_B_ACQ_ON] & ~ctrl[`ATC_B_LEGACY];
	assign acq_hit = sel_trig(ctrl[`ATC_B_ACQ_SRC], ctrl[`ATC_B_ACQ_ACT],
		sw_acq, line_rise, line_fall);
	assign ext_frame_hit = sel_trig(ctrl[`ATC_B_FRM_SRC],
		ctrl[`ATC_B_FRM_ACT], sw_frame, line_rise, line_fall);
	// line edge or software frame command when frame trigger on, else internal timer
	assign frame_trig = ctrl[`ATC_B_FRM_ON] ? ext_frame_hit
		: timer_ready;

	// internal acquisition start whenever the gate is off
	assign acq_start = (state == atc_pkg::ATC_ST_WAIT_ACQ) &&
		(acq_gate ? acq_hit : 1'b1);
	// frame triggers count only while awaiting a frame; an edge that
	// lands while the exposure path is busy is dropped, not queued
	assign accept = (state == atc_pkg::ATC_ST_WAIT_FRAME) && frame_trig &&
		!frame_busy;
	// a frame count of zero behaves as one
	assign burst_last = ({1'b0, burst_cnt} + 1'b1) >= {1'b0, frame_count};

	// ------------------------------------------------------------------
	// acquisition state machine
	// ------------------------------------------------------------------

	// with the gate off the burst just restarts in place
	always_comb begin
		next_state = state;
		case (state)
			atc_pkg::ATC_ST_WAIT_ACQ: begin
				if (acq_start) begin
					next_state = atc_pkg::ATC_ST_WAIT_FRAME;
				end
			end
			atc_pkg::ATC_ST_WAIT_FRAME: begin
				if (accept && burst_last && acq_gate) begin
					next_state = atc_pkg::ATC_ST_WAIT_ACQ;
				end
			end
			default: next_state = atc_pkg::ATC_ST_WAIT_ACQ;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= atc_pkg::ATC_ST_WAIT_ACQ;
		end else begin
			state <= next_state;
		end
	end

	// frames taken in the current burst
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			burst_cnt <= '0;
		end else if (acq_start) begin
			burst_cnt <= '0;
		end else if (accept) begin
			burst_cnt <= burst_last ? '0 : burst_cnt + 1'b1;
		end
	end

	// frame start pulse and status levels, all registered
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			frame_start <= 1'b0;
			waiting_acq <= 1'b1;
			waiting_frame <= 1'b0;
		end else begin
			frame_start <= accept;
			waiting_acq <= (next_state == atc_pkg::ATC_ST_WAIT_ACQ);
			waiting_frame <= (next_state == atc_pkg::ATC_ST_WAIT_FRAME);
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// cycles since the last accepted frame trigger, for the rate checks;
	// counted from the accept so it is never stale in the pulse cycle
	logic [PER_W-1:0] since_cnt;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			since_cnt <= '1;
		end else if (accept) begin
			since_cnt <= PER_W'(1);
		end else if (since_cnt != '1) begin
			since_cnt <= since_cnt + 1'b1;
		end
	end

	acq_auto_a: assert property (
		state == atc_pkg::ATC_ST_WAIT_ACQ && !acq_gate
		|=> state == atc_pkg::ATC_ST_WAIT_FRAME ##1 waiting_frame)
		else $error("internal acquisition start missing");

	frame_cause_a: assert property (
		frame_start |-> $past(state) == atc_pkg::ATC_ST_WAIT_FRAME &&
		$past(frame_trig) && !$past(frame_busy))
		else $error("frame start without a trigger");

	line_rise_a: assert property (
		ctrl[`ATC_B_FRM_ON] && !ctrl[`ATC_B_FRM_SRC] &&
		!ctrl[`ATC_B_FRM_ACT] && line_rise && !frame_busy &&
		state == atc_pkg::ATC_ST_WAIT_FRAME |=> frame_start)
		else $error("line rising edge not taken as frame start");

	acq_edge_a: assert property (
		state == atc_pkg::ATC_ST_WAIT_ACQ && acq_gate &&
		!ctrl[`ATC_B_ACQ_SRC] && !ctrl[`ATC_B_ACQ_ACT] && line_rise
		|=> state == atc_pkg::ATC_ST_WAIT_FRAME)
		else $error("acquisition edge did not arm");

	burst_end_a: assert property (
		accept && acq_gate &&
		({1'b0, burst_cnt} + 1'b1) == {1'b0, frame_count}
		|=> waiting_acq && burst_cnt == '0)
		else $error("burst did not end at frame count");

	burst_hold_a: assert property (
		state == atc_pkg::ATC_ST_WAIT_ACQ && acq_gate && !acq_hit
		|=> state == atc_pkg::ATC_ST_WAIT_ACQ)
		else $error("left awaiting acquisition without trigger");

	ignore_frame_a: assert property (
		$past(state) == atc_pkg::ATC_ST_WAIT_ACQ |-> !frame_start)
		else $error("frame started while awaiting acquisition");

	internal_frame_a: assert property (
		!ctrl[`ATC_B_FRM_ON] && timer_ready && !frame_busy &&
		state == atc_pkg::ATC_ST_WAIT_FRAME |=> frame_start)
		else $error("internal frame trigger not used");

	rate_gap_a: assert property (
		accept && !ctrl[`ATC_B_FRM_ON] && ctrl[`ATC_B_RATE_EN]
		|-> since_cnt >= frame_period && since_cnt >= PER_W'(MIN_GAP))
		else $error("internal frame faster than programmed rate");

	max_rate_a: assert property (
		!ctrl[`ATC_B_FRM_ON] && !ctrl[`ATC_B_RATE_EN] && !frame_busy &&
		state == atc_pkg::ATC_ST_WAIT_FRAME &&
		since_cnt >= PER_W'(MIN_GAP) |-> accept)
		else $error("rate disabled but frame held back");

	legacy_a: assert property (
		ctrl[`ATC_B_LEGACY] && state == atc_pkg::ATC_ST_WAIT_ACQ
		|=> state == atc_pkg::ATC_ST_WAIT_FRAME)
		else $error("legacy mode waited for acquisition trigger");

	burst_clear_a: assert property (
		acq_start |=> burst_cnt == '0 && !waiting_acq)
		else $error("burst count not cleared on start");

	burst_done_c: cover property (
		accept && burst_last && acq_gate ##1 waiting_acq);
	ext_frame_c: cover property (
		ctrl[`ATC_B_FRM_ON] && !ctrl[`ATC_B_FRM_SRC] && frame_start);
	free_run_c: cover property (
		!ctrl[`ATC_B_FRM_ON] && frame_start ##[1:40] frame_start);
	sw_acq_c: cover property (sw_acq && acq_start);

endmodule

`default_nettype wire

// ===== atc_line_dev.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// external sensing device on input line 1
// ------------------------------------------------------------
module atc_line_dev (
	input wire logic sys_clk,
	output logic line1
);
	// idle low: a push-pull sensor output, never left floating
	initial line1 = 1'b0;

	// one rising edge per call; one edge per wanted frame or burst
	task automatic pulse(input int hi, input int lo);
		@(posedge sys_clk);
		line1 <= 1'b1;
		repeat (hi) @(posedge sys_clk);
		line1 <= 1'b0;
		repeat (lo) @(posedge sys_clk);
	endtask
endmodule

`default_nettype wire

// ===== atc_trigger_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module atc_trigger_ctrl_tb;
	logic sys_clk, nrst, avs_read, avs_write, frame_busy, line1, wa, wf, fs;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic avs_waitrequest;
	int errors = 0, tests_run = 0, frames = 0, f0, n;

	// ------------------------------------------------------------
	// design and far side
	// ------------------------------------------------------------
	atc_trigger_ctrl i_atc_trigger_ctrl (.sys_clk(sys_clk), .nrst(nrst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .line1_in(line1),
		.frame_busy(frame_busy), .frame_start(fs), .waiting_acq(wa),
		.waiting_frame(wf));
	atc_line_dev i_atc_line_dev (.sys_clk(sys_clk), .line1(line1));

	// ------------------------------------------------------------
	// clock, frame tally, watchdog
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// tally kept apart so scenarios compare deltas, avoiding a race
	always @(posedge sys_clk) if (fs === 1'b1) frames <= frames + 1;
	initial begin
		#(40000 * 5);
		errors++;
		results();
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is sampled low, then one idle edge
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0 && k < 100) begin
			@(posedge sys_clk);
			k++;
		end
		if (k == 100) errors++;
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	// cycles until the next frame start, capped
	task automatic gap(input int lim);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (fs !== 1'b1 && n < lim);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		bus(1'b0, 5'h00, 32'h0); check(rd, 32'h0000_0004);
		bus(1'b0, 5'h04, 32'h0); check(rd, 32'h0000_0001);
		bus(1'b0, 5'h08, 32'h0); check(rd, 32'h0003_0D40);
		bus(1'b0, 5'h0C, 32'h0); check(rd, 32'h0000_0000);
		bus(1'b0, 5'h10, 32'h0); check(rd, 32'h0000_0002);
		bus(1'b0, 5'h18, 32'h0); check(rd, 32'h0000_0000);
		bus(1'b0, 5'h14, 32'h0); check(rd, 32'h0000_0000);
	endtask
	// free run: rate from the period, then the fastest gap
	task automatic t_free();
		bus(1'b1, 5'h08, 32'h0000_001E);
		bus(1'b1, 5'h00, 32'hFFFF_FF80);
		bus(1'b0, 5'h00, 32'h0); check(rd, 32'h0000_0080);
		gap(400); gap(400); gap(400);
		check(n, 32'h0000_001E);
		bus(1'b1, 5'h00, 32'h0000_0000);
		gap(400); gap(400); gap(400);
		check(n, 32'h0000_0014);
	endtask
	// frame trigger from line 1 rising edge only
	task automatic t_ext();
		bus(1'b1, 5'h00, 32'h0000_0002);
		idle(30);
		f0 = frames;
		idle(100);
		check(frames - f0, 32'h0);
		i_atc_line_dev.pulse(10, 30);
		check(frames - f0, 32'h1);
		frame_busy <= 1'b1;
		i_atc_line_dev.pulse(10, 30);
		check(frames - f0, 32'h1);
		frame_busy <= 1'b0;
	endtask
	// bursts of three internal frames per line edge
	task automatic t_burst();
		bus(1'b1, 5'h04, 32'h0000_0003);
		bus(1'b1, 5'h00, 32'h0000_0081);
		n = 0;
		while (wa !== 1'b1 && n < 300) begin
			@(posedge sys_clk);
			n++;
		end
		check(wa, 1'b1);
		bus(1'b0, 5'h10, 32'h0); check(rd, 32'h0000_0001);
		f0 = frames;
		idle(100);
		check(frames - f0, 32'h0);
		repeat (2) begin
			i_atc_line_dev.pulse(4, 4);
			check(wf, 1'b1);
			n = 0;
			while (wa !== 1'b1 && n < 300) begin
				@(posedge sys_clk);
				n++;
			end
			idle(100);
		end
		check(frames - f0, 32'h6);
	endtask
	// both triggers on the line: first edge arms, next one exposes
	task automatic t_both();
		bus(1'b1, 5'h04, 32'h0000_0001);
		bus(1'b1, 5'h00, 32'h0000_0003);
		f0 = frames;
		i_atc_line_dev.pulse(4, 20);
		check(frames - f0, 32'h0);
		check(wf, 1'b1);
		i_atc_line_dev.pulse(4, 20);
		check(frames - f0, 32'h1);
		check(wa, 1'b1);
	endtask
	// software acquisition command, frames on the falling line edge
	task automatic t_soft();
		bus(1'b1, 5'h04, 32'h0000_0002);
		bus(1'b1, 5'h00, 32'h0000_004B);
		f0 = frames;
		bus(1'b1, 5'h0C, 32'h0000_0001);
		idle(2);
		check(wf, 1'b1);
		i_atc_line_dev.pulse(30, 20);
		check(frames - f0, 32'h1);
		check(wf, 1'b1);
		bus(1'b0, 5'h14, 32'h0); check(rd, 32'h0000_0001);
		i_atc_line_dev.pulse(4, 20);
		check(frames - f0, 32'h2);
		check(wa, 1'b1);
	endtask
	// legacy: acquisition trigger absent, every rising edge is a frame
	task automatic t_legacy();
		bus(1'b1, 5'h00, 32'h0000_0007);
		idle(20);
		f0 = frames;
		i_atc_line_dev.pulse(4, 30);
		i_atc_line_dev.pulse(4, 30);
		check(frames - f0, 32'h2);
		check(wa, 1'b0);
		// software frame command stands in for the line in legacy mode
		bus(1'b1, 5'h00, 32'h0000_0026);
		f0 = frames;
		bus(1'b1, 5'h0C, 32'h0000_0002);
		idle(4);
		check(frames - f0, 32'h1);
	endtask

	// ------------------------------------------------------------
	// verdict
	// ------------------------------------------------------------
	task automatic results();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		nrst = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h0;
		frame_busy = 1'b0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_free();
		t_ext();
		t_burst();
		t_both();
		t_soft();
		t_legacy();
		results();
	end
endmodule

`default_nettype wire
